//--- gpc_pkg.sv
package gpc_pkg;

	// ------------------------------------------------------------
	// register map, byte addresses on an 8-bit axi4-lite address
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CFG_LOW = 8'h18;
	localparam logic [7:0] OFS_CFG_HIGH = 8'h1c;
	localparam logic [7:0] OFS_INT_STATUS = 8'h40;
	localparam logic [7:0] OFS_INT_MASK = 8'h44;

	// ------------------------------------------------------------
	// field layout of the two configuration words
	// ------------------------------------------------------------
	localparam int NUM_PINS = 12;
	localparam int LO_PINS = 4;
	localparam int HI_PINS = 8;
	localparam int FSEL_LO_POS = 12;
	localparam int DRV_LO_POS = 8;
	localparam int DIR_LO_POS = 4;
	localparam int DAT_LO_POS = 0;
	localparam int FSEL_HI_POS = 24;
	localparam int DRV_HI_POS = 16;
	localparam int DIR_HI_POS = 8;
	localparam int DAT_HI_POS = 0;

	// ------------------------------------------------------------
	// fallback values when neither eeprom nor otp holds an image
	// ------------------------------------------------------------
	localparam logic [11:0] FSEL_FALLBACK = 12'hfff;
	localparam logic [11:0] ZERO_FALLBACK = 12'h000;

	// ------------------------------------------------------------
	// axi response codes
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// per-pin configuration fields, also the shape of a reset image
	typedef struct packed {
		logic [11:0] fsel;
		logic [11:0] drv;
		logic [11:0] dir;
		logic [11:0] dout;
	} gpc_image_type;

	// axi4-lite master-to-slave signals
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} gpc_axi_req_type;

	// axi4-lite slave-to-master signals
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gpc_axi_rsp_type;

endpackage : gpc_pkg

//--- gpc_top.sv
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
module gpc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire gpc_pkg::gpc_axi_req_type axi_req,
	output gpc_pkg::gpc_axi_rsp_type axi_rsp,
	input wire logic [11:0] pin_in,
	output logic [11:0] pin_out,
	output logic [11:0] pin_oe,
	input wire logic [11:0] alt_out,
	input wire logic [11:0] alt_oe,
	input wire logic eeprom_present,
	input wire gpc_pkg::gpc_image_type eeprom_image,
	input wire logic otp_programmed,
	input wire gpc_pkg::gpc_image_type otp_image,
	input wire logic usb_reset,
	input wire logic soft_reinit,
	input wire logic reset_protect,
	input wire logic [11:0] wake_enable,
	input wire logic [11:0] wake_polarity,
	output logic wake_event,
	output logic irq
);
	import gpc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		gpc_image_type cfg;
		logic [11:0] pin_smp;
		logic [11:0] act_prev;
		logic [11:0] status;
		logic [11:0] mask;
		logic wake;
		logic [11:0] pad_out;
		logic [11:0] pad_oe;
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gpc_state_type;

	gpc_state_type st_ff;
	gpc_state_type nxt_st;

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------

	// eeprom wins over otp, both over the fixed fallbacks
	function automatic gpc_image_type pick_image(input logic ee_ok, input gpc_image_type ee,
		input logic otp_ok, input gpc_image_type otp);
		gpc_image_type img;
		img.fsel = FSEL_FALLBACK;
		img.drv = ZERO_FALLBACK;
		img.dir = ZERO_FALLBACK;
		img.dout = ZERO_FALLBACK;
		if (ee_ok) begin
			img = ee;
		end else if (otp_ok) begin
			img = otp;
		end
		return img;
	endfunction : pick_image

	// pins 0-3 word; data field carries whatever level vector is passed
	function automatic logic [31:0] word_low(input gpc_image_type c, input logic [11:0] d);
		logic [31:0] w;
		w = 32'h0;
		w[FSEL_LO_POS +: LO_PINS] = c.fsel[LO_PINS-1:0];
		w[DRV_LO_POS +: LO_PINS] = c.drv[LO_PINS-1:0];
		w[DIR_LO_POS +: LO_PINS] = c.dir[LO_PINS-1:0];
		w[DAT_LO_POS +: LO_PINS] = d[LO_PINS-1:0];
		return w;
	endfunction : word_low

	// pins 4-11 word
	function automatic logic [31:0] word_high(input gpc_image_type c, input logic [11:0] d);
		logic [31:0] w;
		w = 32'h0;
		w[FSEL_HI_POS +: HI_PINS] = c.fsel[NUM_PINS-1:LO_PINS];
		w[DRV_HI_POS +: HI_PINS] = c.drv[NUM_PINS-1:LO_PINS];
		w[DIR_HI_POS +: HI_PINS] = c.dir[NUM_PINS-1:LO_PINS];
		w[DAT_HI_POS +: HI_PINS] = d[NUM_PINS-1:LO_PINS];
		return w;
	endfunction : word_high

	// byte strobes to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return m;
	endfunction : strb_mask

	// mapped addresses answer okay, anything else slverr
	function automatic logic addr_hit(input logic [7:0] a);
		logic hit;
		hit = (a == OFS_CFG_LOW) || (a == OFS_CFG_HIGH) ||
			(a == OFS_INT_STATUS) || (a == OFS_INT_MASK);
		return hit;
	endfunction : addr_hit

	// ------------------------------------------------------------
	// combinational next state
	// ------------------------------------------------------------
	logic [11:0] gpio_in;
	logic [11:0] active;
	logic [11:0] edge_evt;
	logic aw_now;
	logic w_now;
	logic ar_now;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [31:0] wr_mask;
	logic [31:0] merged;
	logic reload;
	logic status_rd;
	gpc_image_type reload_img;

	// handshake outputs are combinational off the state
	assign axi_rsp.awready = ~st_ff.aw_got & ~st_ff.bvalid;
	assign axi_rsp.wready = ~st_ff.w_got & ~st_ff.bvalid;
	assign axi_rsp.bvalid = st_ff.bvalid;
	assign axi_rsp.bresp = st_ff.bresp;
	assign axi_rsp.arready = ~st_ff.rvalid;
	assign axi_rsp.rvalid = st_ff.rvalid;
	assign axi_rsp.rdata = st_ff.rdata;
	assign axi_rsp.rresp = st_ff.rresp;
	assign pin_out = st_ff.pad_out;
	assign pin_oe = st_ff.pad_oe;
	assign wake_event = st_ff.wake;
	assign irq = |(st_ff.status & st_ff.mask);

	always_comb begin
		nxt_st = st_ff;
		reload_img = pick_image(eeprom_present, eeprom_image, otp_programmed, otp_image);
		// protected resets leave the fields alone
		reload = (usb_reset | soft_reinit) & ~reset_protect;

		// pins are synchronous, one sample register is enough
		nxt_st.pin_smp = pin_in;
		gpio_in = ~st_ff.cfg.fsel & ~st_ff.cfg.dir;
		active = ~(st_ff.pin_smp ^ wake_polarity);
		nxt_st.act_prev = active;
		// an edge into the active level, only on gpio inputs
		edge_evt = gpio_in & active & ~st_ff.act_prev;
		nxt_st.wake = |(edge_evt & wake_enable);

		// write channel: address and data taken in either order
		aw_now = axi_req.awvalid & axi_rsp.awready;
		w_now = axi_req.wvalid & axi_rsp.wready;
		wr_addr = st_ff.aw_got ? st_ff.awaddr : axi_req.awaddr;
		wr_data = st_ff.w_got ? st_ff.wdata : axi_req.wdata;
		wr_mask = strb_mask(st_ff.w_got ? st_ff.wstrb : axi_req.wstrb);
		merged = 32'h0;
		if (aw_now) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axi_req.awaddr;
		end
		if (w_now) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = axi_req.wdata;
			nxt_st.wstrb = axi_req.wstrb;
		end
		if (st_ff.bvalid && axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		if ((st_ff.aw_got | aw_now) && (st_ff.w_got | w_now)) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
			case (wr_addr)
				OFS_CFG_LOW: begin
					// merge against the stored output value, not the pin level
					merged = (word_low(st_ff.cfg, st_ff.cfg.dout) & ~wr_mask) |
						(wr_data & wr_mask);
					nxt_st.cfg.fsel[LO_PINS-1:0] = merged[FSEL_LO_POS +: LO_PINS];
					nxt_st.cfg.drv[LO_PINS-1:0] = merged[DRV_LO_POS +: LO_PINS];
					nxt_st.cfg.dir[LO_PINS-1:0] = merged[DIR_LO_POS +: LO_PINS];
					nxt_st.cfg.dout[LO_PINS-1:0] = merged[DAT_LO_POS +: LO_PINS];
				end
				OFS_CFG_HIGH: begin
					merged = (word_high(st_ff.cfg, st_ff.cfg.dout) & ~wr_mask) |
						(wr_data & wr_mask);
					nxt_st.cfg.fsel[NUM_PINS-1:LO_PINS] = merged[FSEL_HI_POS +: HI_PINS];
					nxt_st.cfg.drv[NUM_PINS-1:LO_PINS] = merged[DRV_HI_POS +: HI_PINS];
					nxt_st.cfg.dir[NUM_PINS-1:LO_PINS] = merged[DIR_HI_POS +: HI_PINS];
					nxt_st.cfg.dout[NUM_PINS-1:LO_PINS] = merged[DAT_HI_POS +: HI_PINS];
				end
				OFS_INT_MASK: begin
					merged = ({20'h0, st_ff.mask} & ~wr_mask) | (wr_data & wr_mask);
					nxt_st.mask = merged[NUM_PINS-1:0];
				end
				default: begin
					merged = 32'h0;
				end
			endcase
		end

		// read channel: answer one cycle after the address is taken
		ar_now = axi_req.arvalid & axi_rsp.arready;
		status_rd = 1'b0;
		if (st_ff.rvalid && axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (ar_now) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = addr_hit(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
			case (axi_req.araddr)
				OFS_CFG_LOW: nxt_st.rdata = word_low(st_ff.cfg, st_ff.pin_smp);
				OFS_CFG_HIGH: nxt_st.rdata = word_high(st_ff.cfg, st_ff.pin_smp);
				OFS_INT_STATUS: begin
					nxt_st.rdata = {20'h0, st_ff.status};
					status_rd = 1'b1;
				end
				OFS_INT_MASK: nxt_st.rdata = {20'h0, st_ff.mask};
				default: nxt_st.rdata = 32'h0;
			endcase
		end

		// read clears what it returned; a new event in that cycle still sets
		nxt_st.status = (status_rd ? 12'h000 : st_ff.status) | edge_evt;

		// image reload beats a register write in the same cycle
		if (reload) begin
			nxt_st.cfg = reload_img;
		end

		// pad drive from the settings that will be in force
		for (int i = 0; i < NUM_PINS; i++) begin
			if (nxt_st.cfg.fsel[i]) begin
				nxt_st.pad_out[i] = alt_out[i];
				nxt_st.pad_oe[i] = alt_oe[i];
			end else if (!nxt_st.cfg.dir[i]) begin
				nxt_st.pad_out[i] = 1'b0;
				nxt_st.pad_oe[i] = 1'b0;
			end else if (nxt_st.cfg.drv[i]) begin
				nxt_st.pad_out[i] = nxt_st.cfg.dout[i];
				nxt_st.pad_oe[i] = 1'b1;
			end else begin
				// open drain only ever pulls low
				nxt_st.pad_out[i] = 1'b0;
				nxt_st.pad_oe[i] = ~nxt_st.cfg.dout[i];
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// sync reset may sample the image ports; the pads stay released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.cfg <= pick_image(eeprom_present, eeprom_image,
				otp_programmed, otp_image);
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_reload;
		(usb_reset || soft_reinit) && !reset_protect;
	endsequence

	sequence s_wr_both;
		axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
	endsequence

	sequence s_rd_low;
		axi_req.arvalid && axi_rsp.arready && (axi_req.araddr == OFS_CFG_LOW);
	endsequence

	// the pads hold their reset value for one edge after release, so skip that edge
	property p_alt_owns;
		$past(aresetn) |-> ((pin_oe ^ $past(alt_oe)) & st_ff.cfg.fsel) == 12'h000;
	endproperty
	a_alt_owns: assert property (p_alt_owns)
		else $error("alternate function lost the pad");

	property p_input_released;
		(pin_oe & ~st_ff.cfg.fsel & ~st_ff.cfg.dir) == 12'h000;
	endproperty
	a_input_released: assert property (p_input_released)
		else $error("input pin driven");

	property p_push_pull;
		$past(aresetn) |-> ((~st_ff.cfg.fsel & st_ff.cfg.dir & st_ff.cfg.drv) &
			~(pin_oe & ~(pin_out ^ st_ff.cfg.dout))) == 12'h000;
	endproperty
	a_push_pull: assert property (p_push_pull)
		else $error("push-pull pin not driving its data bit");

	property p_open_drain;
		$past(aresetn) |-> ((~st_ff.cfg.fsel & st_ff.cfg.dir & ~st_ff.cfg.drv) & (pin_out |
			(pin_oe ^ ~st_ff.cfg.dout))) == 12'h000;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("open-drain pin driven high");

	property p_reload_fsel;
		s_reload |=> st_ff.cfg == $past(reload_img);
	endproperty
	a_reload_fsel: assert property (p_reload_fsel)
		else $error("reload did not restore the image");

	property p_fallback;
		s_reload ##0 (!eeprom_present && !otp_programmed) |=>
			(st_ff.cfg.fsel == FSEL_FALLBACK) && (st_ff.cfg.drv == ZERO_FALLBACK) &&
			(st_ff.cfg.dir == ZERO_FALLBACK) && (st_ff.cfg.dout == ZERO_FALLBACK);
	endproperty
	a_fallback: assert property (p_fallback)
		else $error("fallback values wrong");

	property p_protected;
		(usb_reset || soft_reinit) && reset_protect && !axi_rsp.bvalid &&
			!st_ff.aw_got && !st_ff.w_got && !axi_req.awvalid |=> $stable(st_ff.cfg);
	endproperty
	a_protected: assert property (p_protected)
		else $error("protected reset altered a field");

	property p_read_level;
		s_rd_low |=> axi_rsp.rvalid &&
			(axi_rsp.rdata[DAT_LO_POS +: LO_PINS] == $past(st_ff.pin_smp[LO_PINS-1:0]));
	endproperty
	a_read_level: assert property (p_read_level)
		else $error("data field does not show the pin level");

	property p_wake_input;
		wake_event |-> $past((|(~st_ff.cfg.fsel & ~st_ff.cfg.dir & wake_enable)), 1);
	endproperty
	a_wake_input: assert property (p_wake_input)
		else $error("wake from a pin that is not an enabled input");

	property p_status_input;
		((st_ff.status & ~$past(st_ff.status)) & ~$past(~st_ff.cfg.fsel & ~st_ff.cfg.dir)) ==
			12'h000;
	endproperty
	a_status_input: assert property (p_status_input)
		else $error("event latched from a non-input pin");

	property p_write_resp;
		s_wr_both |=> axi_rsp.bvalid ##0 (axi_rsp.bresp ==
			(addr_hit($past(axi_req.awaddr)) ? RESP_OKAY : RESP_SLVERR));
	endproperty
	a_write_resp: assert property (p_write_resp)
		else $error("write response missing or wrong");

endmodule : gpc_top

//--- gpc_pins_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// pad side: external circuitry on the twelve pins
// ------------------------------------------------------------
module gpc_pins_model (
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe,
	input wire logic [11:0] ext_drive,
	output logic [11:0] pin_level
);
	// a driven pad wins; a released pad shows whatever the outside drives
	// open-drain release needs the outside pull, so ext_drive stands in for it
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule : gpc_pins_model

//--- gpc_top_bench.sv
`timescale 1ns/1ps
module gpc_top_bench;
	import gpc_pkg::*;
	logic aclk;
	logic aresetn;
	gpc_axi_req_type axi_req;
	gpc_axi_rsp_type axi_rsp;
	logic [11:0] pin_level, pin_out, pin_oe, alt_out, alt_oe, ext_drive;
	logic eeprom_present, otp_programmed, usb_reset, soft_reinit, reset_protect;
	gpc_image_type eeprom_image, otp_image;
	logic [11:0] wake_enable, wake_polarity;
	logic wake_event, irq;
	logic [1:0] last_resp;
	logic [31:0] rd_data;
	int miscompares, samples_checked;
	logic [31:0] wake_cnt = 32'h0;
	logic [31:0] wake_base;
	logic [3:0] wr_strb;

	// ------------------------------------------------------------
	// clock, design and pad model
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	gpc_top i_gpc_top (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
		.alt_oe(alt_oe), .eeprom_present(eeprom_present), .eeprom_image(eeprom_image),
		.otp_programmed(otp_programmed), .otp_image(otp_image), .usb_reset(usb_reset),
		.soft_reinit(soft_reinit), .reset_protect(reset_protect), .wake_enable(wake_enable),
		.wake_polarity(wake_polarity), .wake_event(wake_event), .irq(irq));
	gpc_pins_model i_gpc_pins_model (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_drive(ext_drive), .pin_level(pin_level));

	// one-cycle wake pulses are counted at the edge where they stand
	always @(posedge aclk) begin
		if (wake_event === 1'b1)
			wake_cnt <= wake_cnt + 32'h1;
	end

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// a fresh edge first, so no strobe is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= wr_strb;
		axi_req.bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (axi_req.awvalid && axi_rsp.awready === 1'b1)
				axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready === 1'b1)
				axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid === 1'b1) begin
				last_resp = axi_rsp.bresp;
				break;
			end
		end
		axi_req.bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		axi_req.rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (axi_req.arvalid && axi_rsp.arready === 1'b1)
				axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid === 1'b1) begin
				rd_data = axi_rsp.rdata;
				last_resp = axi_rsp.rresp;
				break;
			end
		end
		axi_req.rready <= 1'b0;
	endtask : rd

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		check(rd_data, exp);
	endtask : rd_chk

	// one-cycle reload request, usb reset or soft reinit
	task automatic pulse(input bit use_usb);
		@(posedge aclk);
		if (use_usb)
			usb_reset <= 1'b1;
		else
			soft_reinit <= 1'b1;
		@(posedge aclk);
		usb_reset <= 1'b0;
		soft_reinit <= 1'b0;
		tick(3);
	endtask : pulse

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// watchdog, far beyond the hundred-odd cycles the tests need
	// ------------------------------------------------------------
	initial begin
		tick(20000);
		miscompares++;
		end_sim;
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		axi_req = '0;
		ext_drive = 12'h3c3;
		alt_out = 12'h000;
		alt_oe = 12'h001;
		eeprom_present = 1'b0;
		otp_programmed = 1'b0;
		eeprom_image = '{fsel: 12'h00a, drv: 12'h0f0, dir: 12'h111, dout: 12'h222};
		otp_image = '{fsel: 12'h0f0, drv: 12'h000, dir: 12'h000, dout: 12'h000};
		usb_reset = 1'b0;
		soft_reinit = 1'b0;
		reset_protect = 1'b0;
		wake_enable = 12'h010;
		wake_polarity = 12'hfff;
		wr_strb = 4'hf;
		miscompares = 0;
		samples_checked = 0;
		tick(8);
		aresetn <= 1'b1;
		tick(3);
		// fallback image; data bits show the outside level
		// pin 0 belongs to its alternate function, which drives it low
		check({20'h0, pin_oe}, 32'h1);
		rd_chk(OFS_CFG_LOW, 32'h0000f002);
		rd_chk(OFS_CFG_HIGH, 32'hff00003c);
		// low pins: two push-pull, two open-drain, all outputs
		wr(OFS_CFG_LOW, 32'h000003f5);
		check({30'h0, last_resp}, {30'h0, RESP_OKAY});
		tick(3);
		check({24'h0, pin_oe[3:0], pin_out[3:0]}, 32'hb1);
		rd_chk(OFS_CFG_LOW, 32'h000003f1);
		wr(OFS_CFG_HIGH, 32'h00ffffa5);
		tick(3);
		check({16'h0, pin_oe[11:4], pin_out[11:4]}, 32'hffa5);
		rd_chk(OFS_CFG_HIGH, 32'h00ffffa5);
		check({30'h0, last_resp}, {30'h0, RESP_OKAY});
		// pin 0 handed to its alternate function
		wr(OFS_CFG_LOW, 32'h000013f5);
		tick(3);
		check({24'h0, pin_oe[3:0], pin_out[3:0]}, 32'hb0);
		alt_out <= 12'hfff;
		tick(3);
		check({24'h0, pin_oe[3:0], pin_out[3:0]}, 32'hb1);
		// reloads: eeprom, blocked by protection, otp, fallback
		alt_oe <= 12'h000;
		ext_drive <= 12'h000;
		// both images present: the eeprom one must win
		eeprom_present <= 1'b1;
		otp_programmed <= 1'b1;
		pulse(1'b0);
		rd_chk(OFS_CFG_LOW, 32'h0000a010);
		rd_chk(OFS_CFG_HIGH, 32'h000f1100);
		reset_protect <= 1'b1;
		eeprom_present <= 1'b0;
		pulse(1'b1);
		rd_chk(OFS_CFG_LOW, 32'h0000a010);
		reset_protect <= 1'b0;
		otp_programmed <= 1'b1;
		pulse(1'b1);
		rd_chk(OFS_CFG_HIGH, 32'h0f000000);
		otp_programmed <= 1'b0;
		pulse(1'b0);
		rd_chk(OFS_CFG_LOW, 32'h0000f000);
		// events: outside drive rises on pin 0, an output already driven high, pins 4 and 5 inputs rise
		wr(OFS_CFG_HIGH, 32'h00000000);
		wr(OFS_CFG_LOW, 32'h00000111);
		wr(OFS_INT_MASK, 32'h00000ff0);
		rd(OFS_INT_STATUS);
		wake_base = wake_cnt;
		ext_drive <= 12'h031;
		tick(4);
		check({31'h0, irq}, 32'h1);
		check(wake_cnt - wake_base, 32'h1);
		rd_chk(OFS_INT_STATUS, 32'h00000030);
		tick(2);
		check({31'h0, irq}, 32'h0);
		rd_chk(OFS_INT_STATUS, 32'h00000000);
		// masked event sets status but keeps irq low
		wr(OFS_INT_MASK, 32'h00000000);
		ext_drive <= 12'h071;
		tick(4);
		check({31'h0, irq}, 32'h0);
		rd_chk(OFS_INT_STATUS, 32'h00000040);
		// byte strobes: only byte 1 of the mask word may change
		wr_strb = 4'h2;
		wr(OFS_INT_MASK, 32'h00000fff);
		wr_strb = 4'hf;
		rd_chk(OFS_INT_MASK, 32'h00000f00);
		// unmapped place
		rd(8'h30);
		check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
		check(rd_data, 32'h0);
		wr(8'h30, 32'h00000001);
		check({30'h0, last_resp}, {30'h0, RESP_SLVERR});
		end_sim;
	end
endmodule : gpc_top_bench
